// ### rtl/trs_pkg.sv
// package of offsets, field layouts and state codes for the radio status bank
`default_nettype none
package trs_pkg;
	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [5:0] TRS_ADDR_RADIO_STATE = 6'h35;
	localparam logic [5:0] TRS_ADDR_PIN_STATUS = 6'h38;
	localparam logic [5:0] TRS_ADDR_VCO_DAC = 6'h39;
	localparam logic [5:0] TRS_ADDR_TX_FIFO_LEVEL = 6'h3A;
	// ----------------------------------------
	// field layout and reset values
	// ----------------------------------------
	localparam int TRS_STATE_W = 5;
	localparam int TRS_COUNT_W = 7;
	localparam int TRS_STARVED_BIT = 7;
	localparam int TRS_PIN0_BIT = 0;
	localparam logic [7:0] TRS_DATA_RST = 8'h00;
	// ----------------------------------------
	// radio control state codes
	// ----------------------------------------
	localparam logic [4:0] TRS_ST_SLEEP = 5'h00;
	localparam logic [4:0] TRS_ST_IDLE = 5'h01;
	localparam logic [4:0] TRS_ST_OSC_OFF = 5'h02;
	localparam logic [4:0] TRS_ST_MC_VCO = 5'h03;
	localparam logic [4:0] TRS_ST_MC_REG = 5'h04;
	localparam logic [4:0] TRS_ST_MC_CAL = 5'h05;
	localparam logic [4:0] TRS_ST_WK_VCO = 5'h06;
	localparam logic [4:0] TRS_ST_WK_REG = 5'h07;
	localparam logic [4:0] TRS_ST_CAL_BEGIN = 5'h08;
	localparam logic [4:0] TRS_ST_BW_BOOST = 5'h09;
	localparam logic [4:0] TRS_ST_LOCK = 5'h0A;
	localparam logic [4:0] TRS_ST_CAL_FINISH = 5'h0C;
	localparam logic [4:0] TRS_ST_TX_READY = 5'h12;
	localparam logic [4:0] TRS_ST_TX = 5'h13;
	localparam logic [4:0] TRS_ST_TX_END = 5'h14;
	localparam logic [4:0] TRS_ST_TX_STARVED = 5'h16;

	// true for every code the radio control machine may report
	function automatic logic trs_code_valid(input logic [4:0] code);
		unique case (code)
			TRS_ST_SLEEP, TRS_ST_IDLE, TRS_ST_OSC_OFF, TRS_ST_MC_VCO,
			TRS_ST_MC_REG, TRS_ST_MC_CAL, TRS_ST_WK_VCO, TRS_ST_WK_REG,
			TRS_ST_CAL_BEGIN, TRS_ST_BW_BOOST, TRS_ST_LOCK,
			TRS_ST_CAL_FINISH, TRS_ST_TX_READY, TRS_ST_TX, TRS_ST_TX_END,
			TRS_ST_TX_STARVED: trs_code_valid = 1'b1;
			default: trs_code_valid = 1'b0;
		endcase
	endfunction
endpackage
`default_nettype wire

// ### rtl/trs_state_filter.sv
// radio state code sanitiser: holds the last legal code
`default_nettype none
module trs_state_filter
	import trs_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// raw code from the control machine
	input wire logic [4:0] i_code,
	input wire logic i_chip_select_n,
	// filtered code
	output logic [4:0] o_code
);
	logic [4:0] code_reg;
	logic [4:0] code_next;

	// ----------------------------------------
	// next code
	// ----------------------------------------
	always_comb begin
		code_next = code_reg;
		if (trs_code_valid(i_code)) begin
			code_next = i_code;
		end
		// select low wakes the chip, so sleep and osc-off never read out
		if (!i_chip_select_n && (code_next == TRS_ST_SLEEP
				|| code_next == TRS_ST_OSC_OFF)) begin
			code_next = TRS_ST_IDLE;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			code_reg <= TRS_ST_IDLE;
		end else begin
			code_reg <= code_next;
		end
	end

	assign o_code = code_reg;

	chk_code_legal: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		trs_code_valid(o_code)) else $error("illegal state code");
	chk_select_wakes: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		!i_chip_select_n |=> (o_code != TRS_ST_SLEEP
		&& o_code != TRS_ST_OSC_OFF))
		else $error("sleep code seen under select");
	chk_code_follows: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(trs_code_valid(i_code) && i_code > TRS_ST_OSC_OFF)
		|=> o_code == $past(i_code))
		else $error("state code not tracked");
endmodule
`default_nettype wire

// ### rtl/trs_status_regs.sv
// read-only radio status register bank
`default_nettype none
// Functional notes
// - state code bits 4:0, bits 7:5 zero
// - codes 00 sleep, 01 idle, 02 osc-off
// - codes 03 to 05 manual calibration substates
// - wakeup 06/07, cal 08/0C, settle 09/0A
// - 12 ready, 13 tx, 14 end, 16 starved
// - unassigned codes never reported
// - select low hides sleep and osc-off
// - pin bit 0 shows uninverted pin level
// - pin status bits 7:1 read zero
// - eight-bit tuning DAC reading, test only
// - fifo level: starved bit 7, count 6:0
module trs_status_regs
	import trs_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// register access port
	input wire logic i_chip_select_n,
	input wire logic i_rd_en,
	input wire logic i_wr_en,
	input wire logic [5:0] i_addr,
	input wire logic [7:0] i_wr_data,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	// sources inside the device
	input wire logic [4:0] i_radio_ctrl_state_code,
	input wire logic i_general_out_pin0,
	input wire logic i_out_pin0_invert,
	input wire logic [7:0] i_vco_tune_dac_value,
	input wire logic i_tx_fifo_starved_flag,
	input wire logic [6:0] i_tx_fifo_byte_count
);
	logic [4:0] state_code;
	logic [7:0] rd_data_reg;
	logic [7:0] rd_data_next;
	logic rd_valid_reg;
	logic rd_valid_next;
	logic pin_level;
	logic [7:0] vreg_radio_state;
	logic [7:0] vreg_pin_status;
	logic [7:0] vreg_tx_fifo_level;
	logic [4:0] shown_code;
	logic read_taken;
	logic read_unmapped;

	trs_state_filter trs_state_filter_inst (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_code(i_radio_ctrl_state_code),
		.i_chip_select_n(i_chip_select_n),
		.o_code(state_code)
	);

	// ----------------------------------------
	// request decode and wake mapping
	// ----------------------------------------
	// select wakes the chip and a read is only taken under select, so a
	// sleep code still in the filter at that first edge is shown as idle
	function automatic logic [4:0] awake_code(input logic [4:0] code);
		if (code == TRS_ST_SLEEP || code == TRS_ST_OSC_OFF) begin
			awake_code = TRS_ST_IDLE;
		end else begin
			awake_code = code;
		end
	endfunction

	// one read of the given register is taken at this edge
	function automatic logic read_hit(input logic cs_n, input logic rd,
			input logic [5:0] addr, input logic [5:0] reg_addr);
		read_hit = !cs_n && rd && addr == reg_addr;
	endfunction

	// unmapped addresses answer zero rather than stalling the host
	function automatic logic addr_mapped(input logic [5:0] addr);
		addr_mapped = addr == TRS_ADDR_RADIO_STATE
			|| addr == TRS_ADDR_PIN_STATUS
			|| addr == TRS_ADDR_VCO_DAC
			|| addr == TRS_ADDR_TX_FIFO_LEVEL;
	endfunction

	assign shown_code = awake_code(state_code);
	assign read_taken = !i_chip_select_n && i_rd_en;
	assign read_unmapped = read_taken && !addr_mapped(i_addr);

	// ----------------------------------------
	// register images
	// ----------------------------------------
	// tap before the output inverter; the invert setting is only for the pin
	assign pin_level = i_general_out_pin0;
	assign vreg_radio_state = {3'h0, shown_code};
	assign vreg_pin_status = {7'h00, pin_level};
	assign vreg_tx_fifo_level = {i_tx_fifo_starved_flag,
		i_tx_fifo_byte_count};

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// writes are decoded nowhere: every register here is status only
	always_comb begin
		rd_data_next = rd_data_reg;
		rd_valid_next = 1'b0;
		if (!i_chip_select_n && i_rd_en) begin
			rd_valid_next = 1'b1;
			unique case (i_addr)
				TRS_ADDR_RADIO_STATE: rd_data_next = vreg_radio_state;
				TRS_ADDR_PIN_STATUS: rd_data_next = vreg_pin_status;
				TRS_ADDR_VCO_DAC: rd_data_next = i_vco_tune_dac_value;
				TRS_ADDR_TX_FIFO_LEVEL: rd_data_next = vreg_tx_fifo_level;
				default: rd_data_next = TRS_DATA_RST;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rd_data_reg <= TRS_DATA_RST;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	assign o_rd_data = rd_data_reg;
	assign o_rd_valid = rd_valid_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_state_upper_zero: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		read_hit(i_chip_select_n, i_rd_en, i_addr, TRS_ADDR_RADIO_STATE)
		|=> o_rd_valid && o_rd_data[7:5] == 3'h0
		&& o_rd_data[4:0] == $past(shown_code))
		else $error("radio state read wrong");
	chk_state_legal: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		read_hit(i_chip_select_n, i_rd_en, i_addr, TRS_ADDR_RADIO_STATE)
		|=> trs_code_valid(o_rd_data[4:0]))
		else $error("unassigned state code read out");
	chk_sleep_hidden: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		read_hit(i_chip_select_n, i_rd_en, i_addr, TRS_ADDR_RADIO_STATE)
		|=> o_rd_data[4:0] != TRS_ST_SLEEP
		&& o_rd_data[4:0] != TRS_ST_OSC_OFF)
		else $error("sleep code read out");
	chk_wake_idle: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(read_hit(i_chip_select_n, i_rd_en, i_addr, TRS_ADDR_RADIO_STATE)
		&& state_code == TRS_ST_SLEEP)
		|=> o_rd_data == {3'h0, TRS_ST_IDLE})
		else $error("woken chip not shown idle");
	chk_pin_raw: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		read_hit(i_chip_select_n, i_rd_en, i_addr, TRS_ADDR_PIN_STATUS)
		|=> o_rd_data == {7'h00, $past(i_general_out_pin0)})
		else $error("pin status read wrong");
	chk_pin_invert_free: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(read_hit(i_chip_select_n, i_rd_en, i_addr, TRS_ADDR_PIN_STATUS)
		&& i_out_pin0_invert)
		|=> o_rd_data[TRS_PIN0_BIT] == $past(i_general_out_pin0))
		else $error("pin status follows inversion");
	chk_dac_read: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		read_hit(i_chip_select_n, i_rd_en, i_addr, TRS_ADDR_VCO_DAC)
		|=> o_rd_data == $past(i_vco_tune_dac_value))
		else $error("dac reading wrong");
	chk_fifo_level: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		read_hit(i_chip_select_n, i_rd_en, i_addr, TRS_ADDR_TX_FIFO_LEVEL)
		|=> o_rd_data[TRS_STARVED_BIT] == $past(i_tx_fifo_starved_flag)
		&& o_rd_data[6:0] == $past(i_tx_fifo_byte_count))
		else $error("fifo level read wrong");

	// port behaviour, independent of which register is read
	chk_write_ignored: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		(i_wr_en && !read_taken) |=> $stable(o_rd_data) && !o_rd_valid)
		else $error("write changed read data");
	chk_unmapped_zero: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		read_unmapped |=> o_rd_valid && o_rd_data == TRS_DATA_RST)
		else $error("unmapped read not zero");
	chk_read_answers: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		read_taken |=> o_rd_valid)
		else $error("read left unanswered");
	chk_no_spurious: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		!read_taken |=> !o_rd_valid)
		else $error("read answer without request");
	chk_data_holds: assert property (@(posedge i_clock)
		disable iff (i_sys_rst)
		!read_taken |=> $stable(o_rd_data))
		else $error("read data moved without a read");
	// left outside any disable so that reset itself is watched
	chk_rst_clear: assert property (@(posedge i_clock)
		i_sys_rst |=> !o_rd_valid && o_rd_data == TRS_DATA_RST)
		else $error("reset left read port busy");

	// ----------------------------------------
	// coverage
	// ----------------------------------------
	cov_read_tx: cover property (@(posedge i_clock)
		o_rd_valid && o_rd_data == {3'h0, TRS_ST_TX});
	cov_read_starved: cover property (@(posedge i_clock)
		o_rd_valid && o_rd_data[TRS_STARVED_BIT]);
	cov_pin_inverted: cover property (@(posedge i_clock)
		o_rd_valid && i_out_pin0_invert && o_rd_data[TRS_PIN0_BIT]);
	// needs select released between accesses to be reached
	cov_sleep_woken: cover property (@(posedge i_clock)
		read_hit(i_chip_select_n, i_rd_en, i_addr, TRS_ADDR_RADIO_STATE)
		&& state_code == TRS_ST_SLEEP);
	cov_write_attempt: cover property (@(posedge i_clock)
		i_wr_en && !i_chip_select_n && i_wr_data != TRS_DATA_RST);
endmodule
`default_nettype wire

// ### tb/trs_host_model.sv
// host model driving the status register access port
`default_nettype none
module trs_host_model (
	// clock and answer
	input wire logic i_clock,
	input wire logic [7:0] i_rd_data,
	input wire logic i_rd_valid,
	// request
	output logic o_chip_select_n,
	output logic o_rd_en,
	output logic o_wr_en,
	output logic [5:0] o_addr,
	output logic [7:0] o_wr_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{o_chip_select_n, o_rd_en, o_wr_en, o_addr, o_wr_data} = 17'h10000;
	end
	// select is released after each access, so sleep codes can settle
	task automatic xfer(input logic wr, input logic [5:0] a,
		input logic [7:0] wd, output logic [7:0] rd, output logic v);
		@(negedge i_clock);
		o_chip_select_n = 1'b0;
		o_rd_en = !wr;
		o_wr_en = wr;
		o_addr = a;
		o_wr_data = wd;
		@(negedge i_clock);
		{o_rd_en, o_wr_en} = 2'h0;
		o_chip_select_n = 1'b1;
		// released lines show the inverse, not the last value
		o_addr = ~a;
		o_wr_data = ~wd;
		rd = i_rd_data;
		v = i_rd_valid;
	endtask
endmodule
`default_nettype wire

// ### tb/trs_status_regs_test.sv
// self-checking bench for the radio status register bank
`default_nettype none
module trs_status_regs_test
	import trs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ------
	// rows: addr, {pin, invert, starved}, dac, count, expected
	// ------
	typedef struct packed {
		logic [5:0] a;
		logic [2:0] m;
		logic [7:0] d;
		logic [6:0] n;
		logic [7:0] e;
	} trs_row_t;
	trs_row_t rows [9] = '{
		'{6'h38, 3'h5, 8'hFF, 7'h7F, 8'h01}, '{6'h38, 3'h7, 8'hFF, 7'h7F, 8'h01},
		'{6'h38, 3'h3, 8'hFF, 7'h7F, 8'h00}, '{6'h39, 3'h7, 8'hA5, 7'h7F, 8'hA5},
		'{6'h39, 3'h0, 8'h5A, 7'h00, 8'h5A}, '{6'h3A, 3'h5, 8'h00, 7'h7F, 8'hFF},
		'{6'h3A, 3'h6, 8'hFF, 7'h40, 8'h40}, '{6'h3A, 3'h1, 8'hFF, 7'h00, 8'h80},
		'{6'h3B, 3'h7, 8'hFF, 7'h7F, 8'h00}};
	localparam logic [31:0] LEGAL = 32'h005C17FF;
	logic clock, sys_rst, cs_n, rd_en, wr_en, rd_valid, pin, inv, flag, vld;
	logic [5:0] addr;
	logic [7:0] wr_data, rd_data, dac, got, prev;
	logic [4:0] code;
	logic [6:0] cnt;
	int miscompares = 0;
	int compares = 0;
	trs_host_model trs_host_model_inst (.i_clock(clock), .i_rd_data(rd_data),
		.i_rd_valid(rd_valid), .o_chip_select_n(cs_n), .o_rd_en(rd_en),
		.o_wr_en(wr_en), .o_addr(addr), .o_wr_data(wr_data));
	trs_status_regs trs_status_regs_inst (.i_clock(clock),
		.i_sys_rst(sys_rst), .i_chip_select_n(cs_n), .i_rd_en(rd_en),
		.i_wr_en(wr_en), .i_addr(addr), .i_wr_data(wr_data),
		.o_rd_data(rd_data), .o_rd_valid(rd_valid),
		.i_radio_ctrl_state_code(code), .i_general_out_pin0(pin),
		.i_out_pin0_invert(inv), .i_vco_tune_dac_value(dac),
		.i_tx_fifo_starved_flag(flag), .i_tx_fifo_byte_count(cnt));
	task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic check_flag(input logic g, input logic e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [5:0] a);
		trs_host_model_inst.xfer(1'b0, a, 8'hFF, got, vld);
		check_flag(vld, 1'b1);
	endtask
	task automatic tally_and_finish();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// whole run is under 100 accesses of two cycles
	initial begin
		#300000;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		{sys_rst, code, pin, inv, dac, flag, cnt} = {1'b1, 5'h1F, 18'h00000};
		repeat (3) @(posedge clock);
		@(negedge clock);
		sys_rst = 1'b0;
		check_byte(rd_data, TRS_DATA_RST);
		check_flag(rd_valid, 1'b0);
		rd(6'h35);
		check_byte(got, 8'h01);
		$display("reset test done");
		foreach (rows[i]) begin
			@(negedge clock);
			{pin, inv, flag} = rows[i].m;
			dac = rows[i].d;
			cnt = rows[i].n;
			rd(rows[i].a);
			check_byte(got, rows[i].e);
		end
		$display("row test done");
		// illegal codes must leave the last legal one showing
		prev = 8'h01;
		for (int c = 0; c < 32; c++) begin
			@(negedge clock);
			code = c[4:0];
			if (LEGAL[c])
				prev = (c == 0 || c == 2) ? 8'h01 : 8'(c);
			rd(6'h35);
			check_byte(got, prev);
		end
		$display("state sweep done");
		trs_host_model_inst.xfer(1'b1, 6'h3A, 8'h5A, got, vld);
		check_flag(vld, 1'b0);
		check_byte(got, 8'h16);
		rd(6'h3A);
		check_byte(got, 8'hFF);
		$display("write test done");
		@(negedge clock);
		sys_rst = 1'b1;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		check_byte(rd_data, TRS_DATA_RST);
		check_flag(rd_valid, 1'b0);
		rd(6'h35);
		check_byte(got, 8'h01);
		$display("mid-run reset test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
